// ---- src/rre_pkg.sv ----
// Purpose: shared constants for the return and rotate execution block
// Assumes: 8-bit data path, opcode classes decoded upstream
// Notes: widths are defaults of module parameters
package rre_pkg;
  localparam int RRE_DATA_W = 8;
  localparam int RRE_PC_W = 13;
  localparam int RRE_ADDR_W = 8;
  localparam int RRE_SP_W = 4;
  localparam int RRE_MSB = 7;
  localparam logic [1:0] RRE_OP_NONE = 2'h0;
  localparam logic [1:0] RRE_OP_RET_LIT = 2'h1;
  localparam logic [1:0] RRE_OP_IRQ_EXIT = 2'h2;
  localparam logic [1:0] RRE_OP_ROT_MEM = 2'h3;
  localparam logic RRE_GIE_RESET = 1'b0;
  typedef enum logic [1:0] {RRE_IDLE, RRE_ROT_WRITE} rre_state_t;
endpackage

// ---- src/rre_rot_if.sv ----
// Purpose: carries a byte to the rotator and its result back
// Assumes: single clock
// Notes: combinational path only
`timescale 1ns/1ps
interface rre_rot_if #(parameter int W = 8);
  logic [W-1:0] din;
  logic [W-1:0] dout;
  modport user (output din, input dout);
  modport rot (input din, output dout);
endinterface

// ---- src/rre_rotl.sv ----
// Purpose: one-bit left rotate of a byte
// Assumes: width from interface
// Notes: pure combinational
`timescale 1ns/1ps
module rre_rotl #(parameter int W = 8)
(
  rre_rot_if.rot bus
);
  genvar g;
  generate
    for (g = 1; g < W; g++)
    begin : g_shift
      assign bus.dout[g] = bus.din[g-1];
    end
  endgenerate
  assign bus.dout[0] = bus.din[W-1];
endmodule

// ---- src/rre_exec.sv ----
// Purpose: executes return-with-literal, interrupt exit and memory rotate-left
// Assumes: decoder gives a one-cycle op strobe; stack pop data valid in same cycle
`timescale 1ns/1ps
module rre_exec
  import rre_pkg::*;
#(
  parameter int DATA_W = RRE_DATA_W,
  parameter int PC_W = RRE_PC_W,
  parameter int ADDR_W = RRE_ADDR_W,
  parameter int SP_W = RRE_SP_W
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_op_valid,
  input wire logic [1:0] i_op_kind,
  input wire logic [DATA_W-1:0] i_imm,
  input wire logic [ADDR_W-1:0] i_mem_addr,
  input wire logic [PC_W-1:0] i_stack_top,
  input wire logic [DATA_W-1:0] i_mem_rdata,
  input wire logic i_irq_pending,
  input wire logic i_gie_clear,
  output logic o_stack_pop,
  output logic [SP_W-1:0] o_stack_ptr,
  output logic o_pc_load,
  output logic [PC_W-1:0] o_pc_target,
  output logic [DATA_W-1:0] o_working_register,
  output logic o_global_irq_enable,
  output logic o_irq_take,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic o_mem_we,
  output logic [DATA_W-1:0] o_mem_wdata,
  output logic o_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // decode
  rre_state_t state_r;
  rre_state_t state_nxt;
  logic [SP_W-1:0] sp_r;
  logic [PC_W-1:0] pc_r;
  logic pc_load_r;
  logic [DATA_W-1:0] wreg_r;
  logic gie_r;
  logic irq_take_r;
  logic exit_seen_r;
  logic [ADDR_W-1:0] addr_r;
  logic we_r;
  logic [DATA_W-1:0] wdata_r;

  function automatic logic kind_is(input logic [1:0] kind, input logic [1:0] want);
    return kind == want;
  endfunction

  wire logic rot_write = (state_r == RRE_ROT_WRITE);
  wire logic accept = i_op_valid && (state_r == RRE_IDLE);
  wire logic do_ret_lit = accept && kind_is(i_op_kind, RRE_OP_RET_LIT);
  wire logic do_exit = accept && kind_is(i_op_kind, RRE_OP_IRQ_EXIT);
  wire logic do_rot = accept && kind_is(i_op_kind, RRE_OP_ROT_MEM);
  wire logic do_pop = do_ret_lit || do_exit;
  wire logic take_irq = exit_seen_r && gie_r && i_irq_pending;

  rre_rot_if #(.W(DATA_W)) rot_bus();
  assign rot_bus.din = i_mem_rdata;
  rre_rotl #(.W(DATA_W)) u_rotl (.bus(rot_bus));

  ////////////////////////////////////////////////////////////////////////////
  // state machine: rotate takes a read cycle then a write cycle
  always_comb
  begin
    case (state_r)
      RRE_IDLE: state_nxt = do_rot ? RRE_ROT_WRITE : RRE_IDLE;
      RRE_ROT_WRITE: state_nxt = RRE_IDLE;
      default: state_nxt = RRE_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_r <= RRE_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pc_load_r <= 1'b0;
    end
    else
    begin
      pc_load_r <= do_pop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // return stack pop and working register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pc_r <= '0;
      sp_r <= '0;
    end
    else if (do_pop)
    begin
      pc_r <= i_stack_top;
      sp_r <= sp_r - 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wreg_r <= '0;
    end
    else if (do_ret_lit)
    begin
      wreg_r <= i_imm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // global interrupt enable: exit wins over a clear in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      gie_r <= RRE_GIE_RESET;
    end
    else if (do_exit)
    begin
      gie_r <= 1'b1;
    end
    else if (i_gie_clear || take_irq)
    begin
      gie_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      exit_seen_r <= 1'b0;
      irq_take_r <= 1'b0;
    end
    else
    begin
      exit_seen_r <= do_exit;
      irq_take_r <= take_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rotate write-back path
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      addr_r <= '0;
    end
    else if (do_rot)
    begin
      addr_r <= i_mem_addr;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      we_r <= 1'b0;
    end
    else
    begin
      we_r <= rot_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rotated byte captured in the read cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wdata_r <= '0;
    end
    else if (rot_write)
    begin
      wdata_r <= rot_bus.dout;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_stack_pop = do_pop;
  assign o_stack_ptr = sp_r;
  assign o_pc_load = pc_load_r;
  assign o_pc_target = pc_r;
  assign o_working_register = wreg_r;
  assign o_global_irq_enable = gie_r;
  assign o_irq_take = irq_take_r;
  assign o_mem_addr = (state_r == RRE_ROT_WRITE) ? i_mem_addr : addr_r;
  assign o_mem_we = we_r;
  assign o_mem_wdata = wdata_r;
  assign o_busy = (state_r != RRE_IDLE) || we_r;
endmodule

// ---- verif/rre_exec_props.sv ----
// Purpose: rre_exec assertions
// Assumes: one clock
// Notes: bound below
`timescale 1ns/1ps
module rre_exec_props (
  input logic i_clk, i_rst, i_op_valid, i_irq_pending, o_stack_pop, o_pc_load,
  input logic o_global_irq_enable, o_irq_take, o_mem_we, o_busy, i_gie_clear,
  input logic [1:0] i_op_kind,
  input logic [7:0] i_imm, i_mem_rdata, o_working_register, o_mem_wdata,
  input logic [12:0] i_stack_top, o_pc_target,
  input logic [3:0] o_stack_ptr
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_ret; i_op_valid && !o_busy && i_op_kind == 2'h1; endsequence
  sequence s_exit; i_op_valid && !o_busy && i_op_kind == 2'h2; endsequence
  sequence s_rot; i_op_valid && !o_busy && i_op_kind == 2'h3; endsequence
  a_ret_pop: assert property (s_ret |-> o_stack_pop ##1 o_pc_load && o_pc_target == $past(i_stack_top))
    else $error("no pop");
  a_lit_load: assert property (s_ret |=> o_working_register == $past(i_imm)) else $error("no lit");
  a_exit_gie: assert property (s_exit |-> o_stack_pop ##1 o_pc_load && o_global_irq_enable)
    else $error("no gie");
  a_irq_entry: assert property (s_exit ##1 i_irq_pending |=> o_irq_take) else $error("no take");
  a_rot_wb: assert property (s_rot ##1 1 |=> o_mem_we && o_mem_wdata == $past({i_mem_rdata[6:0], i_mem_rdata[7]}))
    else $error("bad rot");
  a_sp_dec: assert property (o_stack_pop |=> o_stack_ptr == $past(o_stack_ptr) - 4'h1) else $error("bad sp");
  a_rot_busy: assert property (s_rot |=> o_busy ##1 o_mem_we) else $error("no busy");
  a_exit_wins: assert property (i_op_valid && !o_busy && i_op_kind == 2'h2 && i_gie_clear |=> o_global_irq_enable)
    else $error("exit lost");
  a_gie_clear: assert property (i_gie_clear && !(i_op_valid && i_op_kind == 2'h2) |=> !o_global_irq_enable)
    else $error("clear lost");
endmodule
bind rre_exec rre_exec_props u_props (.*);

// ---- verif/return_and_rotate_exec_bench.sv ----
// Purpose: rre_exec bench
// Assumes: 200 MHz, sync reset
// Notes: driver queues, monitor checks
`timescale 1ns/1ps
module return_and_rotate_exec_bench;
  logic i_clk = 0, i_rst = 1, i_op_valid = 0, i_irq_pending = 0, i_gie_clear = 0, gie_exp = 0;
  logic o_stack_pop, o_pc_load, o_global_irq_enable, o_irq_take, o_mem_we, o_busy;
  logic [1:0] i_op_kind = 0;
  logic [7:0] i_imm = 0, i_mem_addr = 0, i_mem_rdata = 0, wr_exp = 0, o_working_register, o_mem_addr, o_mem_wdata;
  logic [12:0] i_stack_top = 0, o_pc_target;
  logic [3:0] o_stack_ptr, sp_exp = 0;
  logic [31:0] r = 32'h91df;
  logic [25:0] q_ret[$], q_mem[$], q_irq[$];
  int mismatches = 0, checks_done = 0;
  rre_exec dut (.*);
  initial forever #2.5 i_clk = ~i_clk;
  function automatic void step();
    r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
  endfunction
  task automatic chk(input logic [25:0] g, input logic [25:0] e);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic op(input logic [1:0] k, input logic [7:0] d);
    step();
    @(posedge i_clk);
    i_op_valid <= 1;
    i_op_kind <= k;
    i_imm <= r[7:0];
    i_mem_addr <= r[15:8];
    i_stack_top <= r[28:16];
    i_irq_pending <= r[29] & k == 2'h2;
    i_gie_clear <= r[30];
    if (r[30] && k != 2'h2)
      gie_exp = 0;
    if (k == 2'h3)
      q_mem.push_back({10'h0, r[15:8], d[6:0], d[7]});
    else
    begin
      sp_exp--;
      wr_exp = k == 2'h1 ? r[7:0] : wr_exp;
      gie_exp |= k == 2'h2;
      q_ret.push_back({r[28:16], wr_exp, gie_exp, sp_exp});
    end
    if (r[29] && k == 2'h2)
    begin
      q_irq.push_back(26'h1);
      gie_exp = 0;
    end
    @(posedge i_clk);
    i_op_valid <= 0;
    i_gie_clear <= 0;
    i_mem_rdata <= d;
    @(posedge i_clk);
    i_irq_pending <= 0;
    @(posedge i_clk);
  endtask
  initial
  begin
    #5000;
    mismatches++;
    conclude();
  end
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_rst <= 0;
    for (int i = 0; i < 30; i++)
      op(2'(i % 3 + 1), i == 2 ? 8'h80 : i == 5 ? 8'h01 : r[7:0]);
    repeat (4) @(posedge i_clk);
    chk(26'(q_ret.size() + q_mem.size() + q_irq.size()), 26'h0);
    conclude();
  end
  always @(posedge i_clk)
  begin
    if (o_pc_load)
      chk({o_pc_target, o_working_register, o_global_irq_enable, o_stack_ptr}, q_ret.pop_front());
    if (o_mem_we)
      chk({10'h0, o_mem_addr, o_mem_wdata}, q_mem.pop_front());
    if (o_irq_take)
      chk(26'h1, q_irq.pop_front());
  end
endmodule
